/* pkg/scan_sync_pkg.sv */
// Constants and types shared by the forwarded scan trigger logic
// What this block does
// - Head card builds scan begin/finish events as a card without forwarding does, forwards both.
// - Head card holds each scan trigger until the next line start of incoming data.
// - Aligned triggers go to every follower card so all capture the same lines.
// - Each aligned trigger is sent as a high-priority message word in the forwarded stream.
// - Follower cards pass received trigger messages on with the image data.
// - A follower raises a local hardware event on each received trigger message.
// - The raised event is scan begin or scan finish, chosen by message content.
// - Both event kinds are selectable activations of each event input tool.
// - Scan finish may come from a local line count while begin comes forwarded.
// - Scan finish may instead come from the second event input tool.
// - Forwarding output runs at fixed word rate, adding or dropping idle words only.
package scan_sync_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_TOOL = 5'h04;
    localparam logic [4:0] OFS_TSEL = 5'h08;
    localparam logic [4:0] OFS_LEN = 5'h0C;
    localparam logic [4:0] OFS_STAT = 5'h10;
    localparam logic [4:0] OFS_MASK = 5'h14;
    localparam logic [4:0] OFS_STATE = 5'h18;
    // Field positions
    localparam int CTRL_HEAD = 0;
    localparam int CTRL_EN = 1;
    localparam int TOOL2_LSB = 8;
    localparam int TSEL_FIN_LSB = 8;
    localparam int STAT_W = 5;
    localparam int ST_BEGIN = 0;
    localparam int ST_FINISH = 1;
    localparam int ST_MSG_RX = 2;
    localparam int ST_MSG_TX = 3;
    localparam int ST_OVERRUN = 4;
    // Reset values
    localparam logic [31:0] LEN_RESET = 32'h0000_03E8;
    // Stream words: bit pattern of idle and of trigger messages (K-coded)
    localparam logic [31:0] IDLE_WORD = 32'hBC3C_3C3C;
    localparam logic [23:0] MSG_TAG = 24'hFB_5C5C;
    localparam logic [7:0] MSG_BEGIN = 8'h01;
    localparam logic [7:0] MSG_FINISH = 8'h02;
    // Forwarding word rate as a divider of the 100 MHz core clock
    localparam int CLK_MHZ = 100;
    localparam int FWD_WORD_MHZ = 50;
    localparam logic [3:0] FWD_DIV = 4'(CLK_MHZ / FWD_WORD_MHZ);

    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_BEGIN = 2'b01,
        ACT_FINISH = 2'b10
    } tool_act_t;
    typedef enum logic [1:0] {
        SRC_IMMEDIATE = 2'b00,
        SRC_TOOL1 = 2'b01,
        SRC_TOOL2 = 2'b10,
        SRC_LINE_COUNT = 2'b11
    } trig_src_t;
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_ARMED = 2'b01,
        SCAN_ACTIVE = 2'b10
    } scan_state_t;

    function automatic logic is_msg(input logic [31:0] word, input logic k);
        return k && word[31:8] == MSG_TAG;
    endfunction
endpackage

/* pkg/scan_msg_if.sv */
// Carrier between the trigger core and its message inserter and decoder
`timescale 1ns/1ps
interface scan_msg_if;
    logic send_valid;
    logic send_ready;
    logic [7:0] send_kind;
    logic got_begin;
    logic got_finish;
    modport core (output send_valid, output send_kind, input send_ready, input got_begin, input got_finish);
    modport inserter (input send_valid, input send_kind, output send_ready);
    modport decoder (output got_begin, output got_finish);
endinterface

/* logic/scan_msg_inserter.sv */
// Forwarding output: fixed-rate word slots with priority trigger messages
`timescale 1ns/1ps
module scan_msg_inserter (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Incoming stream
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [31:0] rx_word,
    input wire logic rx_k,
    // Core side
    scan_msg_if.inserter msg,
    // Forwarding output
    output logic [31:0] fwd_word,
    output logic fwd_k,
    output logic fwd_strobe
);
    logic [3:0] div;
    logic tick;
    logic [31:0] hold_word;
    logic hold_k;
    logic hold_full;
    logic drop_idle;

    assign tick = div == scan_sync_pkg::FWD_DIV - 4'd1;
    // Idle words give way to a waiting message; a held payload word waits for the next slot
    assign drop_idle = msg.send_valid && rx_k && rx_word == scan_sync_pkg::IDLE_WORD;
    assign rx_ready = !hold_full || tick && !msg.send_valid;
    assign msg.send_ready = tick;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            div <= 4'd0;
        end else begin
            div <= tick ? 4'd0 : div + 4'd1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hold_full <= 1'b0;
            hold_word <= 32'h0000_0000;
            hold_k <= 1'b0;
        end else begin
            if (tick && !msg.send_valid) begin
                hold_full <= 1'b0;
            end
            if (rx_valid && rx_ready && !drop_idle) begin
                hold_full <= 1'b1;
                hold_word <= rx_word;
                hold_k <= rx_k;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            fwd_word <= scan_sync_pkg::IDLE_WORD;
            fwd_k <= 1'b1;
            fwd_strobe <= 1'b0;
        end else begin
            fwd_strobe <= tick;
            if (tick && msg.send_valid) begin
                fwd_word <= {scan_sync_pkg::MSG_TAG, msg.send_kind};
                fwd_k <= 1'b1;
            end else if (tick && hold_full) begin
                fwd_word <= hold_word;
                fwd_k <= hold_k;
            end else if (tick) begin
                fwd_word <= scan_sync_pkg::IDLE_WORD;
                fwd_k <= 1'b1;
            end
        end
    end
endmodule // scan_msg_inserter

/* logic/scan_msg_decoder.sv */
// Recognises trigger message words in the incoming stream
`timescale 1ns/1ps
module scan_msg_decoder (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Accepted incoming words
    input wire logic word_take,
    input wire logic [31:0] rx_word,
    input wire logic rx_k,
    input wire logic follower,
    // Core side
    scan_msg_if.decoder msg
);
    logic hit;

    assign hit = word_take && follower && scan_sync_pkg::is_msg(rx_word, rx_k);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            msg.got_begin <= 1'b0;
            msg.got_finish <= 1'b0;
        end else begin
            msg.got_begin <= hit && rx_word[7:0] == scan_sync_pkg::MSG_BEGIN;
            msg.got_finish <= hit && rx_word[7:0] == scan_sync_pkg::MSG_FINISH;
        end
    end
endmodule // scan_msg_decoder

/* logic/forwarded_scan_trigger_sync.sv */
// Scan trigger alignment, forwarding and follower event tools with register slave
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module forwarded_scan_trigger_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    // Local scan triggers, as a standalone card makes them
    input wire logic begin_trig,
    input wire logic finish_trig,
    // Incoming stream from the host connector
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [31:0] rx_word,
    input wire logic rx_k,
    input wire logic rx_line_start,
    // Forwarding output
    output logic [31:0] fwd_word,
    output logic fwd_k,
    output logic fwd_strobe,
    // Acquisition control
    output logic scan_begin_event,
    output logic scan_finish_event,
    output logic tool_first_pulse,
    output logic tool_second_pulse
);
    scan_msg_if msg();

    logic ack;
    logic take;
    logic rd_take;
    logic wr_take;
    logic [31:0] ctrl;
    logic [31:0] tool_cfg;
    logic [31:0] trig_sel;
    logic [31:0] scan_line_count;
    logic [scan_sync_pkg::STAT_W-1:0] status;
    logic [scan_sync_pkg::STAT_W-1:0] mask;
    logic [scan_sync_pkg::STAT_W-1:0] events;
    logic head;
    logic enable;
    logic word_take;
    logic line_take;
    logic begin_pend;
    logic finish_pend;
    logic begin_aligned;
    logic finish_aligned;
    logic msg_begin_pend;
    logic msg_finish_pend;
    logic overrun;
    logic [31:0] line_cnt;
    logic start_cmd;
    logic stop_cmd;
    scan_sync_pkg::scan_state_t scan_state;
    scan_sync_pkg::scan_state_t next_scan_state;
    scan_sync_pkg::tool_act_t act_first;
    scan_sync_pkg::tool_act_t act_second;
    scan_sync_pkg::trig_src_t src_begin;
    scan_sync_pkg::trig_src_t src_finish;

    function automatic logic tool_fire(input scan_sync_pkg::tool_act_t act, input logic b, input logic f);
        return act == scan_sync_pkg::ACT_BEGIN && b || act == scan_sync_pkg::ACT_FINISH && f;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign head = ctrl[scan_sync_pkg::CTRL_HEAD];
    assign enable = ctrl[scan_sync_pkg::CTRL_EN];
    assign act_first = scan_sync_pkg::tool_act_t'(tool_cfg[1:0]);
    assign act_second = scan_sync_pkg::tool_act_t'(tool_cfg[scan_sync_pkg::TOOL2_LSB +: 2]);
    assign src_begin = scan_sync_pkg::trig_src_t'(trig_sel[1:0]);
    assign src_finish = scan_sync_pkg::trig_src_t'(trig_sel[scan_sync_pkg::TSEL_FIN_LSB +: 2]);

    // Bus slave: one wait cycle, then the answer edge
    assign take = (read || write) && ack;
    assign rd_take = read && ack;
    assign wr_take = write && ack;
    assign waitrequest = (read || write) && !ack;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ack <= 1'b0;
        end else begin
            ack <= (read || write) && !ack;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack) begin
            case (address)
                scan_sync_pkg::OFS_CTRL: readdata <= ctrl;
                scan_sync_pkg::OFS_TOOL: readdata <= tool_cfg;
                scan_sync_pkg::OFS_TSEL: readdata <= trig_sel;
                scan_sync_pkg::OFS_LEN: readdata <= scan_line_count;
                scan_sync_pkg::OFS_STAT: readdata <= 32'(status);
                scan_sync_pkg::OFS_MASK: readdata <= 32'(mask);
                scan_sync_pkg::OFS_STATE: readdata <= {line_cnt[27:0], begin_pend, finish_pend, scan_state};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl <= 32'h0000_0000;
            tool_cfg <= 32'h0000_0000;
            trig_sel <= 32'h0000_0000;
            scan_line_count <= scan_sync_pkg::LEN_RESET;
            mask <= '0;
        end else if (wr_take) begin
            case (address)
                scan_sync_pkg::OFS_CTRL: ctrl <= merge(ctrl, writedata, byteenable) & 32'h0000_0003;
                scan_sync_pkg::OFS_TOOL: tool_cfg <= merge(tool_cfg, writedata, byteenable) & 32'h0000_0303;
                scan_sync_pkg::OFS_TSEL: trig_sel <= merge(trig_sel, writedata, byteenable) & 32'h0000_0303;
                scan_sync_pkg::OFS_LEN: scan_line_count <= merge(scan_line_count, writedata, byteenable);
                scan_sync_pkg::OFS_MASK: mask <= writedata[scan_sync_pkg::STAT_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky status, cleared by reading; a new event in the clearing cycle survives
    assign events = {overrun, msg.send_valid && msg.send_ready, msg.got_begin || msg.got_finish,
                     scan_finish_event, scan_begin_event};

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            status <= '0;
        end else if (rd_take && address == scan_sync_pkg::OFS_STAT) begin
            // Clear only what the read reported: a bit set after the snapshot is kept
            status <= status & ~readdata[scan_sync_pkg::STAT_W-1:0] | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // Head card: hold each trigger until the next line start
    assign word_take = rx_valid && rx_ready;
    assign line_take = word_take && rx_line_start;
    assign begin_aligned = begin_pend && line_take;
    assign finish_aligned = finish_pend && line_take;
    assign overrun = head && enable && (begin_trig && begin_pend || finish_trig && finish_pend);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            begin_pend <= 1'b0;
            finish_pend <= 1'b0;
        end else if (!head || !enable) begin
            begin_pend <= 1'b0;
            finish_pend <= 1'b0;
        end else begin
            begin_pend <= begin_trig || begin_pend && !line_take;
            finish_pend <= finish_trig || finish_pend && !line_take;
        end
    end

    // One message per aligned trigger, ahead of queued data
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            msg_begin_pend <= 1'b0;
            msg_finish_pend <= 1'b0;
        end else begin
            msg_begin_pend <= begin_aligned || msg_begin_pend && !msg.send_ready;
            msg_finish_pend <= finish_aligned || msg_finish_pend && !(msg.send_ready && !msg_begin_pend);
        end
    end

    assign msg.send_valid = msg_begin_pend || msg_finish_pend;
    assign msg.send_kind = msg_begin_pend ? scan_sync_pkg::MSG_BEGIN : scan_sync_pkg::MSG_FINISH;

    // Event input tools
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tool_first_pulse <= 1'b0;
            tool_second_pulse <= 1'b0;
        end else begin
            tool_first_pulse <= !head && tool_fire(act_first, msg.got_begin, msg.got_finish);
            tool_second_pulse <= !head && tool_fire(act_second, msg.got_begin, msg.got_finish);
        end
    end

    // Scan start and stop commands: aligned triggers on the head card (line count may also stop), selected sources on a follower
    always_comb begin
        if (head) begin
            start_cmd = begin_aligned;
            stop_cmd = finish_aligned || src_finish == scan_sync_pkg::SRC_LINE_COUNT && line_take
                       && line_cnt + 32'd1 >= scan_line_count;
        end else begin
            case (src_begin)
                scan_sync_pkg::SRC_TOOL1: start_cmd = tool_first_pulse;
                scan_sync_pkg::SRC_TOOL2: start_cmd = tool_second_pulse;
                scan_sync_pkg::SRC_IMMEDIATE: start_cmd = 1'b1;
                default: start_cmd = 1'b0;
            endcase
            case (src_finish)
                scan_sync_pkg::SRC_LINE_COUNT: stop_cmd = line_take && line_cnt + 32'd1 >= scan_line_count;
                scan_sync_pkg::SRC_TOOL2: stop_cmd = tool_second_pulse;
                scan_sync_pkg::SRC_TOOL1: stop_cmd = tool_first_pulse;
                default: stop_cmd = 1'b0;
            endcase
        end
    end

    always_comb begin
        case (scan_state)
            scan_sync_pkg::SCAN_IDLE: next_scan_state = enable ? scan_sync_pkg::SCAN_ARMED : scan_sync_pkg::SCAN_IDLE;
            scan_sync_pkg::SCAN_ARMED: next_scan_state = !enable ? scan_sync_pkg::SCAN_IDLE
                : start_cmd ? scan_sync_pkg::SCAN_ACTIVE : scan_sync_pkg::SCAN_ARMED;
            scan_sync_pkg::SCAN_ACTIVE: next_scan_state = !enable || stop_cmd ? scan_sync_pkg::SCAN_ARMED
                : scan_sync_pkg::SCAN_ACTIVE;
            default: next_scan_state = scan_sync_pkg::SCAN_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            scan_state <= scan_sync_pkg::SCAN_IDLE;
            scan_begin_event <= 1'b0;
            scan_finish_event <= 1'b0;
        end else begin
            scan_state <= next_scan_state;
            scan_begin_event <= scan_state == scan_sync_pkg::SCAN_ARMED && enable && start_cmd;
            scan_finish_event <= scan_state == scan_sync_pkg::SCAN_ACTIVE && enable && stop_cmd;
        end
    end

    // Lines inside the current scan
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            line_cnt <= 32'h0000_0000;
        end else if (scan_state != scan_sync_pkg::SCAN_ACTIVE) begin
            line_cnt <= 32'h0000_0000;
        end else if (line_take) begin
            line_cnt <= line_cnt + 32'd1;
        end
    end

    scan_msg_inserter u_inserter (
        .clk_sys(clk_sys),
        .reset(reset),
        .rx_valid(rx_valid),
        .rx_ready(rx_ready),
        .rx_word(rx_word),
        .rx_k(rx_k),
        .msg(msg.inserter),
        .fwd_word(fwd_word),
        .fwd_k(fwd_k),
        .fwd_strobe(fwd_strobe)
    );

    scan_msg_decoder u_decoder (
        .clk_sys(clk_sys),
        .reset(reset),
        .word_take(word_take),
        .rx_word(rx_word),
        .rx_k(rx_k),
        .follower(!head),
        .msg(msg.decoder)
    );

    // Checks
    align_line_a: assert property (@(posedge clk_sys) disable iff (reset)
        begin_pend && line_take |=> msg_begin_pend) else $error("aligned begin not queued");
    no_early_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(msg_begin_pend) |-> $past(line_take)) else $error("begin message before line start");
    msg_word_a: assert property (@(posedge clk_sys) disable iff (reset)
        msg.send_valid && msg.send_ready |=> fwd_k && fwd_word[31:8] == scan_sync_pkg::MSG_TAG
        && fwd_strobe) else $error("message word not sent");
    msg_kind_a: assert property (@(posedge clk_sys) disable iff (reset)
        msg_begin_pend && msg.send_ready |=> fwd_word[7:0] == scan_sync_pkg::MSG_BEGIN)
        else $error("wrong message kind");
    relay_a: assert property (@(posedge clk_sys) disable iff (reset)
        !head && word_take && scan_sync_pkg::is_msg(rx_word, rx_k) |=> u_inserter.hold_full
        && u_inserter.hold_word == $past(rx_word)) else $error("message not relayed");
    event_raise_a: assert property (@(posedge clk_sys) disable iff (reset)
        !head && word_take && rx_k && rx_word == {scan_sync_pkg::MSG_TAG, scan_sync_pkg::MSG_FINISH}
        |=> msg.got_finish && !msg.got_begin) else $error("finish event missing");
    pulse_one_a: assert property (@(posedge clk_sys) disable iff (reset)
        msg.got_begin && !$past(msg.got_begin) |=> !msg.got_begin || $past(word_take))
        else $error("event not a single pulse");
    tool_act_a: assert property (@(posedge clk_sys) disable iff (reset)
        !head && msg.got_begin && act_first == scan_sync_pkg::ACT_BEGIN |=> tool_first_pulse)
        else $error("tool did not fire");
    count_stop_a: assert property (@(posedge clk_sys) disable iff (reset)
        !head && enable && scan_state == scan_sync_pkg::SCAN_ACTIVE && src_finish == scan_sync_pkg::SRC_LINE_COUNT
        && line_take && line_cnt + 32'd1 == scan_line_count |=> scan_finish_event) else $error("scan length ignored");
    tool2_stop_a: assert property (@(posedge clk_sys) disable iff (reset)
        !head && enable && scan_state == scan_sync_pkg::SCAN_ACTIVE && src_finish == scan_sync_pkg::SRC_TOOL2
        && tool_second_pulse |=> scan_finish_event) else $error("second tool stop ignored");
    fixed_rate_a: assert property (@(posedge clk_sys) disable iff (reset)
        fwd_strobe |=> !fwd_strobe [*1] ##1 fwd_strobe) else $error("forward rate broken");
endmodule // forwarded_scan_trigger_sync

/* tb/fwd_chain_sink.sv */
// Next card in the forwarding chain: decodes what arrives on the forwarding output
`timescale 1ns/1ps
module fwd_chain_sink (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Forwarding link
    input wire logic [31:0] fwd_word,
    input wire logic fwd_k,
    input wire logic fwd_strobe,
    // Observations
    output int n_beg,
    output int n_fin,
    output logic [31:0] last_data
);
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            n_beg <= 0;
            n_fin <= 0;
            last_data <= 32'h0000_0000;
        end else if (fwd_strobe) begin
            if (fwd_k && fwd_word == {scan_sync_pkg::MSG_TAG, scan_sync_pkg::MSG_BEGIN}) begin
                n_beg <= n_beg + 1;
            end else if (fwd_k && fwd_word == {scan_sync_pkg::MSG_TAG, scan_sync_pkg::MSG_FINISH}) begin
                n_fin <= n_fin + 1;
            end else if (!fwd_k) begin
                last_data <= fwd_word;
            end
        end
    end
endmodule // fwd_chain_sink

/* tb/test_forwarded_scan_trigger_sync.sv */
// Testbench for the forwarded scan trigger block
`timescale 1ns/1ps
module test_forwarded_scan_trigger_sync;
    logic clk_sys = 0, reset = 1, read = 0, write = 0, rx_valid = 0, rx_k = 0, rx_line_start = 0;
    logic begin_trig = 0, finish_trig = 0, waitrequest, irq, rx_ready, fwd_k, fwd_strobe;
    logic [4:0] address = 5'h00;
    logic [31:0] writedata = 32'h0000_0000, rx_word = 32'h0000_0000, readdata, fwd_word, last_data, rd;
    logic sb, sf, tf, ts;
    int n_errors = 0, total_checks = 0, n_beg, n_fin, n_tf = 0, n_ts = 0, n_sb = 0, n_sf = 0;
    always #5 clk_sys = ~clk_sys;
    forwarded_scan_trigger_sync i_dut (.clk_sys(clk_sys), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .irq(irq), .begin_trig(begin_trig), .finish_trig(finish_trig), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_word(rx_word), .rx_k(rx_k), .rx_line_start(rx_line_start), .fwd_word(fwd_word), .fwd_k(fwd_k),
        .fwd_strobe(fwd_strobe), .scan_begin_event(sb), .scan_finish_event(sf), .tool_first_pulse(tf),
        .tool_second_pulse(ts));
    fwd_chain_sink i_sink (.clk_sys(clk_sys), .reset(reset), .fwd_word(fwd_word), .fwd_k(fwd_k),
        .fwd_strobe(fwd_strobe), .n_beg(n_beg), .n_fin(n_fin), .last_data(last_data));
    always @(posedge clk_sys) begin
        if (tf === 1'b1) n_tf++;
        if (ts === 1'b1) n_ts++;
        if (sb === 1'b1) n_sb++;
        if (sf === 1'b1) n_sf++;
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        chk32(32'(got), 32'(exp));
    endtask
    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int i;
        logic done;
        @(posedge clk_sys);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        done = 0;
        for (i = 0; i < 50 && !done; i++) begin
            @(posedge clk_sys);
            done = !waitrequest;
            if (done) rd = readdata;
        end
        read <= 0;
        write <= 0;
        if (!done) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic send(input logic [31:0] w, input logic k, input logic ls);
        int i;
        logic done;
        @(posedge clk_sys);
        rx_valid <= 1;
        rx_word <= w;
        rx_k <= k;
        rx_line_start <= ls;
        done = 0;
        for (i = 0; i < 50 && !done; i++) begin
            @(posedge clk_sys);
            done = rx_ready;
        end
        rx_valid <= 0;
        rx_word <= ~w;
        if (!done) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic pulse_trig(input logic fin);
        @(posedge clk_sys);
        begin_trig <= !fin;
        finish_trig <= fin;
        @(posedge clk_sys);
        begin_trig <= 0;
        finish_trig <= 0;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic regs_reset();
        bus(0, scan_sync_pkg::OFS_LEN, 0);
        chk32(rd, scan_sync_pkg::LEN_RESET);
        bus(0, 5'h1C, 0);
        chk32(rd, 32'h0000_0000);
    endtask
    // Triggers wait for a line start, then leave as messages
    task automatic head_card();
        bus(1, scan_sync_pkg::OFS_CTRL, 32'h0000_0003);
        bus(1, scan_sync_pkg::OFS_MASK, 32'h0000_0008);
        pulse_trig(0);
        chkn(n_beg, 0);
        send(32'h1234_5678, 0, 1);
        repeat (10) @(posedge clk_sys);
        chkn(n_beg, 1);
        chkn(n_sb, 1);
        chk32(last_data, 32'h1234_5678);
        pulse_trig(1);
        send(32'h9ABC_DEF0, 0, 1);
        repeat (10) @(posedge clk_sys);
        chkn(n_fin, 1);
        chkn(n_sf, 1);
        chk32({31'h0, irq}, 32'h0000_0001);
        bus(0, scan_sync_pkg::OFS_STAT, 0);
        chk32(rd & 32'h0000_0008, 32'h0000_0008);
        repeat (3) @(posedge clk_sys);
        chk32({31'h0, irq}, 32'h0000_0000);
    endtask
    // Messages become one-cycle tool pulses and are relayed
    task automatic follower_card();
        int b, t1, t2, s, f;
        // Sources first, so the immediate default never starts a scan
        bus(1, scan_sync_pkg::OFS_TOOL, 32'h0000_0201);
        bus(1, scan_sync_pkg::OFS_TSEL, 32'h0000_0301);
        bus(1, scan_sync_pkg::OFS_LEN, 32'h0000_0002);
        bus(1, scan_sync_pkg::OFS_CTRL, 32'h0000_0002);
        b = n_beg;
        t1 = n_tf;
        t2 = n_ts;
        s = n_sb;
        f = n_sf;
        send({scan_sync_pkg::MSG_TAG, scan_sync_pkg::MSG_BEGIN}, 1, 0);
        repeat (10) @(posedge clk_sys);
        chkn(n_tf - t1, 1);
        chkn(n_ts - t2, 0);
        chkn(n_beg - b, 1);
        chkn(n_sb - s, 1);
        send({scan_sync_pkg::MSG_TAG, scan_sync_pkg::MSG_FINISH}, 1, 0);
        repeat (10) @(posedge clk_sys);
        chkn(n_ts - t2, 1);
        chkn(n_tf - t1, 1);
        chkn(n_sf - f, 0);
        send(32'h0BAD_F00D, 0, 1);
        send(32'h0000_CAFE, 0, 1);
        repeat (10) @(posedge clk_sys);
        chkn(n_sf - f, 1);
        chk32(last_data, 32'h0000_CAFE);
        bus(1, scan_sync_pkg::OFS_TSEL, 32'h0000_0201);
        send({scan_sync_pkg::MSG_TAG, scan_sync_pkg::MSG_BEGIN}, 1, 0);
        send({scan_sync_pkg::MSG_TAG, scan_sync_pkg::MSG_FINISH}, 1, 0);
        repeat (10) @(posedge clk_sys);
        chkn(n_sb - s, 2);
        chkn(n_sf - f, 2);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 0;
        regs_reset();
        head_card();
        follower_card();
        stop_test();
    end
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
endmodule // test_forwarded_scan_trigger_sync
